// ---- design/sps_pkg.sv ----
package sps_pkg;
    // always-on clock figures
    localparam int unsigned CLK_FREQ_HZ = 200_000_000;
    localparam int unsigned CLK_PERIOD_NS = 5;
    // forced power-off hold time, figure as printed
    localparam int unsigned FORCE_OFF_HOLD_S = 4;
    localparam longint unsigned FORCE_OFF_CYCLES =
        longint'(FORCE_OFF_HOLD_S) * longint'(CLK_FREQ_HZ);
    // switch debounce settle time
    localparam int unsigned DEBOUNCE_US = 10_000;
    localparam longint unsigned DEBOUNCE_CYCLES =
        (longint'(DEBOUNCE_US) * 1000) / longint'(CLK_PERIOD_NS);
    // values after reset
    localparam logic SUPPLY_ON_RST = 1'b0;
    localparam logic SYNC_RST = 1'b0;

    typedef enum logic [2:0] {
        SPS_AC_CHECK,
        SPS_STANDBY,
        SPS_SELF_TEST,
        SPS_LEGACY_RUN,
        SPS_ACPI_RUN,
        SPS_HOLD_RELEASE
    } sps_state_t;

    // stored options held in battery-backed configuration memory
    typedef struct packed {
        logic cfg_valid;
        logic restore_power_on_ac_return;
    } sps_cfg_t;

    // software-visible boot phase reported by firmware
    typedef struct packed {
        logic post_done;
        logic acpi_os;
    } sps_sw_t;
endpackage : sps_pkg

// ---- design/sps_debounce.sv ----
`timescale 1ns/1ps
module sps_debounce
    import sps_pkg::*;
#(
    parameter longint unsigned SETTLE_CYCLES = DEBOUNCE_CYCLES
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // raw pin, active low
    input wire logic raw_n,
    // clean level, high while pressed
    output logic pressed
);
    logic meta_r, sync_r, pressed_r, pressed_nxt;
    logic [31:0] cnt_r, cnt_nxt;

    // two-stage synchroniser; the first stage feeds only the second
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            meta_r <= SYNC_RST;
            sync_r <= SYNC_RST;
        end else begin
            meta_r <= ~raw_n;
            sync_r <= meta_r;
        end
    end

    // level must stay steady for the whole settle time before accepted
    always_comb begin
        pressed_nxt = pressed_r;
        cnt_nxt = 32'h0000_0000;
        if (sync_r != pressed_r) begin
            cnt_nxt = cnt_r + 32'h0000_0001;
            if (cnt_r >= 32'(SETTLE_CYCLES - 1)) begin
                pressed_nxt = sync_r;
                cnt_nxt = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            pressed_r <= SYNC_RST;
            cnt_r <= 32'h0000_0000;
        end else begin
            pressed_r <= pressed_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign pressed = pressed_r;
endmodule : sps_debounce

// ---- design/sps_sequencer.sv ----
`timescale 1ns/1ps
module sps_sequencer
    import sps_pkg::*;
#(
    parameter longint unsigned HOLD_CYCLES = FORCE_OFF_CYCLES,
    parameter longint unsigned SETTLE_CYCLES = DEBOUNCE_CYCLES
) (
    // always-on clock, reset on AC restore
    input wire logic core_clk,
    input wire logic reset,
    // front-panel standby switch, low while pressed
    input wire logic standby_sw_n,
    // battery-backed options, stable while running
    input wire sps_cfg_t cfg,
    // boot phase from firmware
    input wire sps_sw_t sw_phase,
    // software power-off request (ACPI OS)
    input wire logic sw_off_req,
    // wake event (e.g. alarm) from always-on logic
    input wire logic wake_event,
    // supply control and status
    output logic supply_on,
    output logic forced_off,
    output sps_state_t state
);
    logic pressed, pressed_q_r, press;
    logic hold_hit;
    logic [39:0] hold_cnt_r, hold_cnt_nxt;
    sps_state_t state_r, state_nxt;
    logic supply_r, supply_nxt, forced_r, forced_nxt;

    sps_debounce #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_deb (
        .core_clk(core_clk),
        .reset(reset),
        .raw_n(standby_sw_n),
        .pressed(pressed)
    );

    // press is the clean rising edge of the debounced switch
    assign press = pressed & ~pressed_q_r;
    assign hold_hit = (hold_cnt_r >= 40'(HOLD_CYCLES));

    // hold timer saturates so a stuck switch never re-triggers power-on
    always_comb begin
        hold_cnt_nxt = 40'h00_0000_0000;
        if (pressed) begin
            hold_cnt_nxt = hold_hit ? hold_cnt_r : hold_cnt_r + 40'h1;
        end
    end

    // power state sequence
    always_comb begin
        state_nxt = state_r;
        supply_nxt = supply_r;
        forced_nxt = 1'b0;
        case (state_r)
            SPS_AC_CHECK: begin
                // wake events from before the outage were cleared by the
                // AC reset; only restore option can power up here
                if (cfg.cfg_valid && cfg.restore_power_on_ac_return) begin
                    state_nxt = SPS_SELF_TEST;
                    supply_nxt = 1'b1;
                end else begin
                    state_nxt = SPS_STANDBY;
                end
            end
            SPS_STANDBY: begin
                supply_nxt = 1'b0;
                if (press || wake_event) begin
                    state_nxt = SPS_SELF_TEST;
                    supply_nxt = 1'b1;
                end
            end
            SPS_SELF_TEST, SPS_LEGACY_RUN: begin
                if (press) begin
                    state_nxt = SPS_HOLD_RELEASE;
                    supply_nxt = 1'b0;
                end else if (state_r == SPS_SELF_TEST && sw_phase.post_done)
                begin
                    state_nxt = sw_phase.acpi_os ? SPS_ACPI_RUN
                                                 : SPS_LEGACY_RUN;
                end
            end
            SPS_ACPI_RUN: begin
                // short press goes to the OS; only its request or a long hold turns off
                if (sw_off_req) begin
                    state_nxt = SPS_STANDBY;
                    supply_nxt = 1'b0;
                end
            end
            SPS_HOLD_RELEASE: begin
                // wait for release so the same press cannot power back up
                supply_nxt = 1'b0;
                if (!pressed) begin
                    state_nxt = SPS_STANDBY;
                end
            end
            default: begin
                state_nxt = SPS_STANDBY;
                supply_nxt = 1'b0;
            end
        endcase
        // long hold overrides every software state
        if (hold_hit && supply_r) begin
            state_nxt = SPS_HOLD_RELEASE;
            supply_nxt = 1'b0;
            forced_nxt = 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_r <= SPS_AC_CHECK;
            supply_r <= SUPPLY_ON_RST;
            forced_r <= 1'b0;
            pressed_q_r <= 1'b0;
            hold_cnt_r <= 40'h00_0000_0000;
        end else begin
            state_r <= state_nxt;
            supply_r <= supply_nxt;
            forced_r <= forced_nxt;
            pressed_q_r <= pressed;
            hold_cnt_r <= hold_cnt_nxt;
        end
    end

    assign supply_on = supply_r;
    assign forced_off = forced_r;
    assign state = state_r;
endmodule : sps_sequencer

// ---- sim/sps_props.sv ----
`timescale 1ns/1ps
module sps_props
    import sps_pkg::*;
#(
    parameter longint unsigned HOLD_CYCLES = 200,
    parameter longint unsigned SETTLE_CYCLES = 4
) (
    // clock, reset, pin, options
    input wire logic core_clk,
    input wire logic reset,
    input wire logic standby_sw_n,
    input wire sps_cfg_t cfg,
    // supply side
    input wire logic supply_on,
    input wire logic forced_off,
    input wire sps_state_t state
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    // pin low-time, so the hold limit is judged at the port
    longint unsigned low_r, low_nxt;
    always_comb low_nxt = standby_sw_n ? '0 : low_r + 1;
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset)
            low_r <= '0;
        else
            low_r <= low_nxt;
    end
    // 2 sync stages, settle count and one state edge fit in 8 low samples
    property p_on; state == SPS_STANDBY && $fell(standby_sw_n) ##0
        !standby_sw_n [*8] |-> supply_on; endproperty
    a_on: assert property (p_on) else $error("no power-up");
    property p_off; state inside {SPS_SELF_TEST, SPS_LEGACY_RUN} &&
        $fell(standby_sw_n) ##0 !standby_sw_n [*8] |-> !supply_on; endproperty
    a_off: assert property (p_off) else $error("no power-down");
    property p_hold; low_r == HOLD_CYCLES + SETTLE_CYCLES + 16 |->
        !supply_on && state == SPS_HOLD_RELEASE; endproperty
    a_hold: assert property (p_hold) else $error("hold ignored");
    property p_pulse; forced_off |->
        !supply_on && low_r >= HOLD_CYCLES ##1 !forced_off; endproperty
    a_pulse: assert property (p_pulse) else $error("bad force");
    property p_blank; $fell(reset) && !cfg.cfg_valid |=>
        state == SPS_STANDBY && !supply_on; endproperty
    a_blank: assert property (p_blank) else $error("blank up");
    property p_back; $fell(reset) && cfg == 2'h3 |=>
        state == SPS_SELF_TEST && supply_on; endproperty
    a_back: assert property (p_back) else $error("no restore");
    property p_wait; $fell(reset) && cfg == 2'h2 |=> !supply_on [*3];
    endproperty
    a_wait: assert property (p_wait) else $error("early up");
    property p_bounce; state == SPS_STANDBY && $fell(standby_sw_n) ##1
        standby_sw_n [*8] |-> !supply_on; endproperty
    a_bounce: assert property (p_bounce) else $error("bounce up");
endmodule : sps_props
bind sps_sequencer sps_props #(.HOLD_CYCLES(HOLD_CYCLES),
    .SETTLE_CYCLES(SETTLE_CYCLES)) sps_props_inst (.core_clk(core_clk),
    .reset(reset), .standby_sw_n(standby_sw_n), .cfg(cfg),
    .supply_on(supply_on), .forced_off(forced_off), .state(state));

// ---- sim/sps_switch_model.sv ----
`timescale 1ns/1ps
module sps_switch_model (
    // clock
    input wire logic core_clk,
    // switch pin, pulled up while released
    output logic standby_sw_n
);
    initial standby_sw_n = 1'b1;
    // hold the button n cycles, then it springs back
    task automatic press(input int n);
        @(posedge core_clk);
        #1 standby_sw_n = 1'b0;
        repeat (n) @(posedge core_clk);
        #1 standby_sw_n = 1'b1;
    endtask : press
endmodule : sps_switch_model

// ---- sim/tb_soft_power_switch_sequencer.sv ----
`timescale 1ns/1ps
module tb_soft_power_switch_sequencer
    import sps_pkg::*;
;
    localparam int HOLD = 200;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    sps_cfg_t cfg = 2'h0;
    sps_sw_t sw_phase = 2'h0;
    logic wake_event = 1'b0;
    logic standby_sw_n, supply_on, forced_off;
    sps_state_t state;
    int errors = 0;
    int compares = 0;
    int forced_n = 0;
    initial forever #2.5 core_clk = ~core_clk;
    sps_switch_model sps_switch_model_inst (.core_clk(core_clk),
        .standby_sw_n(standby_sw_n));
    // short counts keep the run brief
    sps_sequencer #(.HOLD_CYCLES(HOLD), .SETTLE_CYCLES(4))
        sps_sequencer_inst (.core_clk(core_clk), .reset(reset),
        .standby_sw_n(standby_sw_n), .cfg(cfg), .sw_phase(sw_phase),
        .sw_off_req(1'b0), .wake_event(wake_event), .supply_on(supply_on),
        .forced_off(forced_off), .state(state));
    always @(posedge core_clk)
        if (forced_off === 1'b1)
            forced_n++;
    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: %0h vs %0h", $time, seen, exp);
        end
    endtask : check
    task automatic wait_n(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : wait_n
    // ac return; a wake during the outage must be lost
    task automatic t_ac(input sps_cfg_t c, input logic [3:0] exp);
        reset = 1'b1;
        cfg = c;
        sw_phase = 2'h0;
        wake_event = 1'b1;
        wait_n(12);
        wake_event = 1'b0;
        reset = 1'b0;
        wait_n(3);
        check({state, supply_on}, exp);
        $display("ac test done");
    endtask : t_ac
    // press wakes from standby, press in legacy os powers down
    task automatic t_on_off;
        sps_switch_model_inst.press(20);
        wait_n(10);
        check({state, supply_on}, {SPS_SELF_TEST, 1'b1});
        sw_phase = 2'h2;
        wait_n(4);
        sps_switch_model_inst.press(20);
        wait_n(10);
        check({state, supply_on}, {SPS_STANDBY, 1'b0});
        $display("press test done");
    endtask : t_on_off
    // a one-cycle bounce is too short to count
    task automatic t_bounce;
        sps_switch_model_inst.press(1);
        wait_n(12);
        check({state, supply_on}, {SPS_STANDBY, 1'b0});
        $display("bounce test done");
    endtask : t_bounce
    // in the acpi os only a long hold takes power away
    task automatic t_hold;
        wake_event = 1'b1;
        wait_n(1);
        wake_event = 1'b0;
        sw_phase = 2'h3;
        wait_n(4);
        sps_switch_model_inst.press(HOLD + 30);
        wait_n(10);
        check({state, supply_on}, {SPS_STANDBY, 1'b0});
        check(4'(forced_n), 4'h1);
        $display("hold test done");
    endtask : t_hold
    task automatic end_sim;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim
    // tests need about 390 cycles
    initial begin
        #20us;
        errors++;
        end_sim;
    end
    initial begin
        t_ac(2'h0, {SPS_STANDBY, 1'b0});
        t_ac(2'h1, {SPS_STANDBY, 1'b0});
        t_ac(2'h3, {SPS_SELF_TEST, 1'b1});
        t_ac(2'h2, {SPS_STANDBY, 1'b0});
        t_on_off;
        t_bounce;
        t_hold;
        end_sim;
    end
endmodule : tb_soft_power_switch_sequencer
